// *** verilog/mss_seq_map.vh ***
// Constants for the multi stream sequencer
`ifndef MSS_SEQ_MAP_VH
`define MSS_SEQ_MAP_VH
`define MSS_NSTREAM      6
`define MSS_SIDX_W       3
`define MSS_SEC_W        9
`define MSS_CLK_HZ       10000000
`define MSS_TICK_W       24
`define MSS_CONC_W       16
`define MSS_DWELL_DEF_S  9'd30
`define MSS_DUR_DEF_S    9'd60
`define MSS_DUR_MAX_S    9'd360
`define MSS_BLINK_HZ     2
`define MSS_ONE_SEC      24'd10000000
`define MSS_BLINK_CYC    24'd2500000
`endif

// *** verilog/mss_seq.v ***
// Multi stream sequencer: valve selection, purge dwell, measurement timing
// Overview of operation
// R1: Auto mode cycles enabled streams, skipping disabled
// R2: Manual mode steps only on button press
// R3: Energise only the selected stream's valve
// R4: Every switch starts a purge dwell, default 30 s
// R5: Dwell: lamp blinks, display holds stored value
// R6: After dwell: steady lamp, live concentration shown
// R7: Stream held for full duration including dwell
// R8: Dwell length comes from purge delay setting
// R9: Per-stream duration, default 60 s, max 360
// R10: Configurer keeps at least one stream enabled
// R11: At most one valve on, one-hot indication
`timescale 1ns/100ps
`include "mss_seq_map.vh"
module mss_seq #(
  parameter [`MSS_TICK_W-1:0] SEC_CYCLES   = `MSS_ONE_SEC,
  parameter [`MSS_TICK_W-1:0] BLINK_CYCLES = `MSS_BLINK_CYC
) (
  input  wire                          clk_sys,
  input  wire                          arst_n,
  input  wire                          manual_stepping,
  input  wire                          step_button,
  input  wire [`MSS_NSTREAM-1:0]       stream_enable,
  input  wire [`MSS_SEC_W-1:0]         purge_delay_setting,
  input  wire [`MSS_NSTREAM*`MSS_SEC_W-1:0] stream_duration,
  input  wire [`MSS_CONC_W-1:0]        live_conc,
  output reg  [`MSS_NSTREAM-1:0]       valve_q,
  output reg                           lamp_q,
  output reg  [`MSS_CONC_W-1:0]        display_q,
  output reg                           measuring_q
);

  localparam ST_DWELL   = 1'b0;
  localparam ST_MEASURE = 1'b1;

  // Pin inputs pass two flops; the step button passes a third for edge detect
  reg                      btn_s1_q, btn_s2_q, btn_s3_q;
  reg                      man_s1_q, man_s2_q;
  reg [`MSS_NSTREAM-1:0]   en_s1_q, en_s2_q;
  // Settings come from panel logic outside this clock
  // Multi-bit settings are quasi-static; a torn word lasts one cycle
  reg [`MSS_SEC_W-1:0]     pd_s1_q, pd_s2_q;
  reg [`MSS_NSTREAM*`MSS_SEC_W-1:0] dur_s1_q, dur_s2_q;
  // Marks streams that hold a stored reading
  reg [`MSS_NSTREAM-1:0]   seen_q;

  reg [`MSS_SIDX_W-1:0]    idx_q;
  reg                      state_q;
  reg [`MSS_TICK_W-1:0]    tick_q;
  reg [`MSS_SEC_W-1:0]     sec_q;
  reg [`MSS_TICK_W-1:0]    blink_cnt_q;
  reg                      blink_q;
  reg [`MSS_CONC_W-1:0]    last_conc_q [0:`MSS_NSTREAM-1];

  // Next enabled stream after cur; stays put if none enabled
  function [`MSS_SIDX_W-1:0] next_en;
    input [`MSS_SIDX_W-1:0]  cur;
    input [`MSS_NSTREAM-1:0] en;
    integer k;
    reg [`MSS_SIDX_W-1:0] cand;
    reg found;
    begin
      next_en = cur;
      found   = 1'b0;
      cand    = cur;
      for (k = 1; k <= `MSS_NSTREAM; k = k + 1) begin
        if (cand == `MSS_NSTREAM - 1)
          cand = {`MSS_SIDX_W{1'b0}};
        else
          cand = cand + 1'b1;
        if (!found && en[cand]) begin
          next_en = cand;
          found   = 1'b1;
        end
      end
    end
  endfunction

  // Clamp configured duration into the legal range
  function [`MSS_SEC_W-1:0] dur_of;
    input [`MSS_SIDX_W-1:0] i;
    reg [`MSS_SEC_W-1:0] d;
    begin
      d = dur_s2_q[i*`MSS_SEC_W +: `MSS_SEC_W];
      if (d > `MSS_DUR_MAX_S)
        dur_of = `MSS_DUR_MAX_S; // R9
      else
        dur_of = d;
    end
  endfunction

  wire                    btn_press = btn_s2_q & ~btn_s3_q;
  wire                    sec_tick  = (tick_q == SEC_CYCLES - 1'b1);
  wire [`MSS_SEC_W-1:0]   dur_cur   = dur_of(idx_q);
  // Dwell never outlasts the duration; a zero dwell skips purge
  wire [`MSS_SEC_W-1:0]   dwell_len = (pd_s2_q > dur_cur) ?
                                      dur_cur : pd_s2_q; // R8
  wire                    dur_done  = sec_tick &&
                                      (sec_q + 1'b1 >= dur_cur); // R7
  wire                    advance   = man_s2_q ? btn_press          // R2
                                               : dur_done;          // R1
  wire [`MSS_SIDX_W-1:0]  idx_nxt   = next_en(idx_q, en_s2_q);      // R1
  // A step with no other enabled stream is ignored
  wire                    switch_now = advance && (idx_nxt != idx_q);
  // Next value of measuring_q; lamp and display follow it so that
  // they change in the same cycle as the measure flag
  wire                    meas_nxt  = !switch_now &&
                                      ((state_q == ST_MEASURE) ||
                                       (sec_q >= dwell_len));       // R6

  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      btn_s1_q <= 1'b0;
      btn_s2_q <= 1'b0;
      btn_s3_q <= 1'b0;
      man_s1_q <= 1'b0;
      man_s2_q <= 1'b0;
      en_s1_q  <= {`MSS_NSTREAM{1'b1}};
      en_s2_q  <= {`MSS_NSTREAM{1'b1}};
      pd_s1_q  <= `MSS_DWELL_DEF_S;
      pd_s2_q  <= `MSS_DWELL_DEF_S;
      dur_s1_q <= {`MSS_NSTREAM{`MSS_DUR_DEF_S}};
      dur_s2_q <= {`MSS_NSTREAM{`MSS_DUR_DEF_S}};
    end else begin
      btn_s1_q <= step_button;
      btn_s2_q <= btn_s1_q;
      btn_s3_q <= btn_s2_q;
      man_s1_q <= manual_stepping;
      man_s2_q <= man_s1_q;
      en_s1_q  <= stream_enable;
      en_s2_q  <= en_s1_q;
      pd_s1_q  <= purge_delay_setting;
      pd_s2_q  <= pd_s1_q;
      dur_s1_q <= stream_duration;
      dur_s2_q <= dur_s1_q;
    end
  end

  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      idx_q       <= {`MSS_SIDX_W{1'b0}};
      state_q     <= ST_DWELL;
      tick_q      <= {`MSS_TICK_W{1'b0}};
      sec_q       <= {`MSS_SEC_W{1'b0}};
      valve_q     <= {`MSS_NSTREAM{1'b0}};
      measuring_q <= 1'b0;
    end else begin
      valve_q <= {`MSS_NSTREAM{1'b0}};
      valve_q[idx_q] <= 1'b1; // R3 R11
      if (switch_now) begin
        idx_q       <= idx_nxt;
        state_q     <= ST_DWELL; // R4
        tick_q      <= {`MSS_TICK_W{1'b0}};
        sec_q       <= {`MSS_SEC_W{1'b0}};
        measuring_q <= 1'b0;
        // Break before make: all valves off for the switch cycle
        valve_q     <= {`MSS_NSTREAM{1'b0}}; // R11
      end else begin
        tick_q <= sec_tick ? {`MSS_TICK_W{1'b0}} : tick_q + 1'b1;
        if (dur_done && man_s2_q)
          sec_q <= sec_q; // Manual mode measures on until stepped
        else if (dur_done)
          sec_q <= {`MSS_SEC_W{1'b0}};
        else if (sec_tick)
          sec_q <= sec_q + 1'b1;
        case (state_q)
          ST_DWELL: begin
            if (sec_q >= dwell_len) begin
              state_q     <= ST_MEASURE; // R6
              measuring_q <= 1'b1;
            end
          end
          ST_MEASURE: begin
            measuring_q <= 1'b1;
            if (dur_done && !man_s2_q) begin
              // Lone enabled stream: re-purge is pointless, keep measuring
              state_q <= ST_MEASURE;
            end
          end
          default: state_q <= ST_DWELL;
        endcase
      end
    end
  end

  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      blink_cnt_q <= {`MSS_TICK_W{1'b0}};
      blink_q     <= 1'b0;
      lamp_q      <= 1'b0;
      display_q   <= {`MSS_CONC_W{1'b0}};
      seen_q      <= {`MSS_NSTREAM{1'b0}};
    end else begin
      // Unmeasured streams show zero rather than stale memory
      if (state_q == ST_MEASURE)
        seen_q[idx_q] <= 1'b1;
      if (blink_cnt_q == BLINK_CYCLES - 1'b1) begin
        blink_cnt_q <= {`MSS_TICK_W{1'b0}};
        blink_q     <= ~blink_q;
      end else begin
        blink_cnt_q <= blink_cnt_q + 1'b1;
      end
      if (!meas_nxt) begin
        lamp_q    <= blink_q;            // R5
        display_q <= seen_q[idx_q] ? last_conc_q[idx_q]
                                   : {`MSS_CONC_W{1'b0}}; // R5
      end else begin
        lamp_q    <= 1'b1;               // R6
        display_q <= live_conc;          // R6
      end
    end
  end

  // Stored readings have no reset; array stays plain memory
  always @(posedge clk_sys) begin
    if (state_q == ST_MEASURE)
      last_conc_q[idx_q] <= live_conc;
  end

endmodule

// *** dv/mss_chain_model.sv ***
// Stand-in for the valve manifold and measuring chain
`timescale 1ns/100ps
module mss_chain_model (
  input  wire        clk_sys,
  input  wire [5:0]  valve_q,
  output wire [15:0] live_conc
);
  reg [9:0] cnt_q = 10'h000;
  // Only the open valve feeds the analyser; top bits name it
  assign live_conc = {valve_q, cnt_q};
  always @(posedge clk_sys) cnt_q <= cnt_q + 10'h001;
endmodule

// *** dv/mss_seq_sva.sv ***
// Port assertions for the stream sequencer
`timescale 1ns/100ps
module mss_seq_sva (
  input wire        clk_sys,
  input wire        arst_n,
  input wire        manual_stepping,
  input wire        step_button,
  input wire [15:0] live_conc,
  input wire [5:0]  valve_q,
  input wire        lamp_q,
  input wire [15:0] display_q,
  input wire        measuring_q
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  // Long enough for the sync and any switch in flight
  sequence idle_s;
    (manual_stepping && !step_button)[*8];
  endsequence
  one_valve_a: assert property ($onehot0(valve_q))
    else $error("two valves open");
  meas_valve_a: assert property (measuring_q |-> $onehot(valve_q))
    else $error("measuring without a valve");
  meas_lamp_a: assert property (measuring_q |-> lamp_q)
    else $error("lamp not steady in measure");
  live_disp_a: assert property (measuring_q && $past(measuring_q)
    |-> display_q == $past(live_conc) || display_q == $past(live_conc, 2))
    else $error("display not live");
  dwell_disp_a: assert property (!measuring_q && !$past(measuring_q)
    && valve_q != 6'h00 && $past(valve_q, 2) == valve_q |-> $stable(display_q))
    else $error("display moved in dwell");
  gap_first_a: assert property ($changed(valve_q) && valve_q != 6'h00
    |-> $past(valve_q) == 6'h00) else $error("no gap at switch");
  meas_stop_a: assert property ($fell(measuring_q) |-> valve_q == 6'h00)
    else $error("measure ended without switch");
  man_hold_a: assert property (idle_s |=> $stable(valve_q))
    else $error("manual mode stepped alone");
endmodule
bind mss_seq mss_seq_sva mss_seq_sva_i (.clk_sys, .arst_n, .manual_stepping,
  .step_button, .live_conc, .valve_q, .lamp_q, .display_q, .measuring_q);

// *** dv/testbench.sv ***
// Self-checking bench for the stream sequencer
`timescale 1ns/100ps
module testbench;
  reg         clk_sys = 1'b0;
  reg         arst_n = 1'b0;
  reg         manual_stepping = 1'b0;
  reg         step_button = 1'b0;
  reg  [5:0]  stream_enable = 6'h29;
  reg  [8:0]  purge_delay_setting = 9'h002;
  reg  [53:0] stream_duration = {6{9'h004}};
  wire [15:0] live_conc;
  wire [5:0]  valve_q;
  wire        lamp_q;
  wire [15:0] display_q;
  wire        measuring_q;
  int         mismatches = 0;
  int         compares = 0;
  always #50 clk_sys = ~clk_sys;
  // One second is 10 cycles here, so 2 s dwell and 4 s stay
  mss_seq #(.SEC_CYCLES(24'd10), .BLINK_CYCLES(24'd2)) mss_seq_i (.clk_sys,
    .arst_n, .manual_stepping, .step_button, .stream_enable,
    .purge_delay_setting, .stream_duration, .live_conc, .valve_q, .lamp_q,
    .display_q, .measuring_q);
  mss_chain_model mss_chain_model_i (.clk_sys, .valve_q, .live_conc);
  task chk_v(input [15:0] g, input [15:0] e);
    compares++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task chk_n(input int n, input int lo, input int hi);
    chk_v({15'h0000, n < lo || n > hi}, 16'h0000);
  endtask
  task sw(input [5:0] e, input bit h);
    int n;
    int t;
    reg l;
    n = 0;
    t = 0;
    while (valve_q !== 6'h00 && n < 900) begin
      @(posedge clk_sys); #1;
      n++;
    end
    n = 0;
    @(posedge clk_sys); #1;
    chk_v(valve_q, e);
    l = lamp_q;
    while (measuring_q !== 1'b1 && n < 900) begin
      @(posedge clk_sys); #1;
      n++;
      t += (lamp_q !== l);
      l = lamp_q;
      if (h && n == 5) chk_v(display_q[15:10], e);
    end
    chk_n(n, 18, 22);
    chk_n(t, 3, 20);
    chk_v(lamp_q, 1'b1);
    if (manual_stepping) return;
    while (valve_q !== 6'h00 && n < 900) begin
      @(posedge clk_sys); #1;
      n++;
    end
    chk_n(n, 38, 42);
  endtask
  task finish_test;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    #500000;
    mismatches++;
    finish_test;
  end
  initial begin
    repeat (3) @(posedge clk_sys);
    arst_n <= 1'b1;
    sw(6'h01, 1'b0);
    sw(6'h08, 1'b0);
    sw(6'h20, 1'b0);
    sw(6'h01, 1'b1);
    @(posedge clk_sys);
    manual_stepping <= 1'b1;
    repeat (600) @(posedge clk_sys);
    #1;
    chk_v(valve_q, 6'h08);
    @(posedge clk_sys);
    step_button <= 1'b1;
    sw(6'h20, 1'b0);
    @(posedge clk_sys);
    step_button <= 1'b0;
    finish_test;
  end
endmodule
